// ### logic/spb_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SPB_MAP_SVH
`define SPB_MAP_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SPB_OFS_DATA   3'h0
`define SPB_OFS_IEN    3'h1
`define SPB_OFS_FIFO   3'h2
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SPB_IEN_RDA    0
`define SPB_IEN_THRE   1
`define SPB_IEN_LS     2
`define SPB_IEN_MS     3
`define SPB_FCR_EN     0
`define SPB_FCR_RXCLR  1
`define SPB_FCR_TXCLR  2
`define SPB_FCR_TRGLO  6
`define SPB_FCR_TRGHI  7
// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define SPB_IEN_RST    4'h0
`define SPB_FCR_RST    8'h00
`define SPB_TRG_RST    2'h0
`define SPB_IID_NONE   4'h1
`define SPB_IID_LS     4'h6
`define SPB_IID_RDA    4'h4
`define SPB_IID_TMO    4'hC
`define SPB_IID_THRE   4'h2
`define SPB_IID_MS     4'h0
`define SPB_TRG_1      5'h01
`define SPB_TRG_4      5'h04
`define SPB_TRG_8      5'h08
`define SPB_TRG_14     5'h0E
// ---------------------------------------------------------------
// timing counts, in sample ticks (16 per bit time)
// ---------------------------------------------------------------
`define SPB_OVS_RATE   16
`define SPB_CHAR_BITS  10
`define SPB_TMO_CHARS  4
`define SPB_TMO_TICKS  (`SPB_TMO_CHARS * `SPB_CHAR_BITS * `SPB_OVS_RATE)
`define SPB_TICK_MID   4'h7
`define SPB_TICK_LAST  4'hF
`define SPB_TX_LAST    4'h9
`endif

// ### logic/spb_pkg.sv
// types shared by the serial port buffer block
package spb_pkg;
  // register port request, one cycle per access
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spb_req_s;
  // receiver sequencing, one-hot
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } spb_rx_e;
endpackage

// ### logic/spb_uart.sv
// serial port data buffers, fifos, interrupt enable and identification
//
// Function
// - receive byte shifts in LSB first, then moves to receive data register.
// - transmit byte copied to hidden shifter only after previous byte finished.
// - offset 0, access bit clear: read gives receive data, write loads transmit.
// - all four enable bits clear means no pending interrupt, no interrupt out.
// - enable bit 0 allows data available and, in fifo mode, timeout.
// - enable bit 1 allows the transmit holding empty interrupt.
// - enable bit 2 allows the receiver line status interrupt.
// - enable bit 3 allows the modem status interrupt.
// - interrupt enable bits 7..4 always read zero.
// - fifo control bit 0 enables both fifos; clearing it empties both.
// - bits 1 and 2 flush receive and transmit fifo, shifters untouched, self clear.
// - bit 3 has no effect; bits 4 and 5 reserved.
// - bits 7..6 pick receive trigger of 1, 4, 8 or 14 bytes.
// - every fifo control write is kept in a readable shadow copy.
// - priority is line status, data or timeout, transmit empty, modem status.
// - identification value held steady while the host reads it.
// - identification bit 0 reads zero when an enabled interrupt is pending.
// - identification codes 0001, 0110, 0100, 1100, 0010, 0000.
// - bit 3 only for timeout in fifo mode; 5..4 zero; 7..6 show fifo mode.
// - timeout after four idle character times with receive fifo not empty.
// - each interrupt cleared by its own read or write event.
// - access bit set moves offsets 0 and 1 to the divisor latches.
// - interrupt pin driven only while the output gate bit is one.
`timescale 1ns/10ps
`include "spb_map.svh"

module spb_uart
  import spb_pkg::*;
#(
  parameter int DEPTH = 16
)
(
  // clock and reset
  input  wire logic     ref_clk,
  input  wire logic     reset,
  // register port
  input  wire spb_req_s regReq,
  output logic [7:0]    regRdData,
  // serial line and bit timing
  input  wire logic     rxSerial,
  input  wire logic     sampleTick,
  output logic          txSerial,
  // neighbouring register blocks
  input  wire logic     divisorLatchAccessBit,
  input  wire logic     lineStatusPend,
  input  wire logic     modemStatusPend,
  input  wire logic     interruptOutputGateBit,
  output logic [7:0]    fifoCtlShadow,
  // interrupt pin
  output logic          serIrq,
  output logic          serIrqOe_n
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [9:0] TMO_LAST = 10'(`SPB_TMO_TICKS - 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0]    ien_r;
  logic          fifoEn_r;
  logic [1:0]    trig_r;
  logic          rxMeta_r, rxSync_r;
  spb_rx_e       rxState_r, rxState_nxt;
  logic [3:0]    rxTick_r;
  logic [2:0]    rxBits_r;
  logic [7:0]    rxShift_r;
  logic [7:0]    rxMem [DEPTH];
  logic [AW-1:0] rxWp_r, rxRp_r;
  logic [CW-1:0] rxCount_r;
  logic [9:0]    tmoCnt_r;
  logic          tmo_r;
  logic [7:0]    txMem [DEPTH];
  logic [AW-1:0] txWp_r, txRp_r;
  logic [CW-1:0] txCount_r;
  logic          txBusy_r;
  logic [9:0]    txShift_r;
  logic [3:0]    txTick_r, txBits_r;
  logic          txWasEmpty_r, threPend_r;
  logic          rxDone;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire dataSel = (regReq.addr == `SPB_OFS_DATA) & ~divisorLatchAccessBit;
  wire ienSel  = (regReq.addr == `SPB_OFS_IEN)  & ~divisorLatchAccessBit;
  wire fifoSel = (regReq.addr == `SPB_OFS_FIFO);
  wire rdRx    = regReq.rd & dataSel;
  wire txWr    = regReq.wr & dataSel;
  wire ienWr   = regReq.wr & ienSel;
  wire rdIen   = regReq.rd & ienSel;
  wire fcrWr   = regReq.wr & fifoSel;
  wire rdIir   = regReq.rd & fifoSel;
  wire [7:0] wd = regReq.wdata;

  // a clear of bit 0 empties both fifos whatever else is written
  wire rxFlush = fcrWr & (~wd[`SPB_FCR_EN] | wd[`SPB_FCR_RXCLR]);
  wire txFlush = fcrWr & (~wd[`SPB_FCR_EN] | wd[`SPB_FCR_TXCLR]);

  // ---------------------------------------------------------------
  // fifo occupancy; outside fifo mode each side is a one-byte holder
  // ---------------------------------------------------------------
  wire [CW-1:0] cap     = fifoEn_r ? CW'(DEPTH) : CW'(1);
  wire          rxFull  = rxCount_r >= cap;
  wire          txFull  = txCount_r >= cap;
  wire          rxAny   = rxCount_r != '0;
  wire          txEmpty = txCount_r == '0;
  wire          rxPush  = rxDone & ~rxFull;      // full fifo drops the new byte
  wire          rxPop   = rdRx & rxAny;
  wire          txPush  = txWr & ~txFull;
  wire          txLoad  = ~txBusy_r & ~txEmpty;
  wire [7:0]    rxHead  = rxMem[rxRp_r];
  wire [7:0]    txHead  = txMem[txRp_r];

  // ---------------------------------------------------------------
  // interrupt sources and priority
  // ---------------------------------------------------------------
  wire [4:0] trigLvl = (trig_r == 2'h0) ? `SPB_TRG_1 :
                       (trig_r == 2'h1) ? `SPB_TRG_4 :
                       (trig_r == 2'h2) ? `SPB_TRG_8 : `SPB_TRG_14;
  wire rdaLvl = fifoEn_r ? (rxCount_r >= CW'(trigLvl)) : rxAny;
  wire lsEn   = ien_r[`SPB_IEN_LS] & lineStatusPend;
  wire rdaEn  = ien_r[`SPB_IEN_RDA] & rdaLvl;
  wire tmoEn  = ien_r[`SPB_IEN_RDA] & fifoEn_r & tmo_r;
  wire threEn = ien_r[`SPB_IEN_THRE] & threPend_r;
  wire msEn   = ien_r[`SPB_IEN_MS] & modemStatusPend;
  // bit 3 only ever comes with the timeout code, so it is zero in non-fifo mode
  wire [3:0] iid = lsEn   ? `SPB_IID_LS   :
                   rdaEn  ? `SPB_IID_RDA  :
                   tmoEn  ? `SPB_IID_TMO  :
                   threEn ? `SPB_IID_THRE :
                   msEn   ? `SPB_IID_MS   : `SPB_IID_NONE;
  wire anyPend = iid != `SPB_IID_NONE;
  wire [7:0] iirVal = {fifoEn_r, fifoEn_r, 2'h0, iid};

  // transmit empty: set on the edge into empty, set beats clear
  wire threSet = txEmpty & ~txWasEmpty_r;
  wire threClr = txWr | (rdIir & (iid == `SPB_IID_THRE));
  wire threNxt = threSet | (threPend_r & ~threClr);

  // timeout: any fifo traffic restarts the idle count
  wire rxAct  = rxPush | rxPop | rxFlush;
  wire tmoHit = sampleTick & (tmoCnt_r == TMO_LAST) & rxAny & fifoEn_r & ~rxAct;
  wire tmoNxt = tmoHit | (tmo_r & ~rxPop & ~rxFlush & fifoEn_r);

  // read data mux, sampled once so the host sees a frozen value
  wire [7:0] rdNxt = rdRx  ? rxHead :
                     rdIen ? {4'h0, ien_r} :
                     rdIir ? iirVal : 8'h00;

  // ---------------------------------------------------------------
  // register port and control registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    regRdData <= reset ? 8'h00 : rdNxt;
    if (reset)
    begin
      ien_r         <= `SPB_IEN_RST;
      fifoEn_r      <= 1'b0;
      trig_r        <= `SPB_TRG_RST;
      fifoCtlShadow <= `SPB_FCR_RST;
    end
    else
    begin
      if (ienWr)
        ien_r <= wd[3:0];
      if (fcrWr)
      begin
        fifoCtlShadow <= wd;
        fifoEn_r      <= wd[`SPB_FCR_EN];
        // trigger only taken with bit 0 set; bits 3..5 unused
        if (wd[`SPB_FCR_EN])
          trig_r <= wd[`SPB_FCR_TRGHI:`SPB_FCR_TRGLO];
      end
    end
  end

  // interrupt pin, enable low while driving
  always_ff @(posedge ref_clk)
  begin
    serIrq     <= ~reset & anyPend & interruptOutputGateBit;
    serIrqOe_n <= reset | ~interruptOutputGateBit;
  end

  // ---------------------------------------------------------------
  // receiver: line synchroniser and sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    rxMeta_r <= reset ? 1'b1 : rxSerial;
    rxSync_r <= reset ? 1'b1 : rxMeta_r;
  end

  // start bit qualified at mid-bit, then every 16 ticks samples mid-bit
  always_comb
  begin
    rxState_nxt = rxState_r;
    rxDone      = 1'b0;
    case (rxState_r)
      RX_IDLE:
        if (!rxSync_r)
          rxState_nxt = RX_START;
      RX_START:
        if (sampleTick && rxTick_r == `SPB_TICK_MID)
          rxState_nxt = rxSync_r ? RX_IDLE : RX_DATA;
      RX_DATA:
        if (sampleTick && rxTick_r == `SPB_TICK_LAST && rxBits_r == 3'h7)
          rxState_nxt = RX_STOP;
      RX_STOP:
        if (sampleTick && rxTick_r == `SPB_TICK_LAST)
        begin
          rxState_nxt = RX_IDLE;
          rxDone      = 1'b1;
        end
      default:
        rxState_nxt = RX_IDLE;
    endcase
  end

  wire rxSample = (rxState_r == RX_DATA) & sampleTick & (rxTick_r == `SPB_TICK_LAST);

  // hidden shift register, LSB arrives first
  always_ff @(posedge ref_clk)
  begin
    rxState_r <= reset ? RX_IDLE : rxState_nxt;
    rxTick_r  <= (reset || rxState_nxt != rxState_r) ? 4'h0 : rxTick_r + 4'(sampleTick);
    rxBits_r  <= (reset || rxState_r != RX_DATA) ? 3'h0 : rxBits_r + 3'(rxSample);
    if (rxSample)
      rxShift_r <= {rxSync_r, rxShift_r[7:1]};
  end

  // ---------------------------------------------------------------
  // receive fifo and character timeout
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rxPush)
      rxMem[rxWp_r] <= rxShift_r;
  end

  // flush clears pointers only; the shifter keeps assembling
  always_ff @(posedge ref_clk)
  begin
    if (reset || rxFlush)
    begin
      rxWp_r    <= '0;
      rxRp_r    <= '0;
      rxCount_r <= '0;
    end
    else
    begin
      rxWp_r    <= rxWp_r + AW'(rxPush);
      rxRp_r    <= rxRp_r + AW'(rxPop);
      rxCount_r <= rxCount_r + CW'(rxPush) - CW'(rxPop);
    end
  end

  // idle count saturates so the flag cannot retrigger by wrap
  always_ff @(posedge ref_clk)
  begin
    if (reset || rxAct || !rxAny)
      tmoCnt_r <= 10'h000;
    else if (sampleTick && tmoCnt_r != TMO_LAST)
      tmoCnt_r <= tmoCnt_r + 10'h001;
    tmo_r <= ~reset & tmoNxt;
  end

  // ---------------------------------------------------------------
  // transmit fifo and serializer (8 data, no parity, 1 stop)
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (txPush)
      txMem[txWp_r] <= wd;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || txFlush)
    begin
      txWp_r    <= '0;
      txRp_r    <= '0;
      txCount_r <= '0;
    end
    else
    begin
      txWp_r    <= txWp_r + AW'(txPush);
      txRp_r    <= txRp_r + AW'(txLoad);
      txCount_r <= txCount_r + CW'(txPush) - CW'(txLoad);
    end
  end

  // shifter loads only when idle, so a byte in flight is never cut
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      txBusy_r <= 1'b0;
    else if (txLoad)
    begin
      txBusy_r  <= 1'b1;
      txShift_r <= {1'b1, txHead, 1'b0};
      txTick_r  <= 4'h0;
      txBits_r  <= 4'h0;
    end
    else if (txBusy_r && sampleTick)
    begin
      txTick_r <= txTick_r + 4'h1;
      if (txTick_r == `SPB_TICK_LAST)
      begin
        txShift_r <= {1'b1, txShift_r[9:1]};
        txBits_r  <= txBits_r + 4'h1;
        txBusy_r  <= txBits_r != `SPB_TX_LAST;
      end
    end
    txSerial <= reset | ~txBusy_r | txShift_r[0];
  end

  always_ff @(posedge ref_clk)
  begin
    txWasEmpty_r <= ~reset & txEmpty;
    threPend_r   <= ~reset & threNxt;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  ien_upper_a: assert property (rdIen |=> regRdData[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  rx_read_a: assert property (rdRx |=> regRdData == $past(rxHead))
    else $error("receive data read wrong");
  ien_off_a: assert property (ien_r == 4'h0 |=> !serIrq)
    else $error("interrupt with all enables clear");
  prio_ls_a: assert property (lsEn && rdIir |=> regRdData[3:0] == `SPB_IID_LS)
    else $error("line status not top priority");
  iir_read_a: assert property (rdIir |=> regRdData[0] == !$past(anyPend)
                               && regRdData[5:4] == 2'h0)
    else $error("identification pending bit wrong");
  iir_mode_a: assert property (rdIir |=> regRdData[7:6] == {2{$past(fifoEn_r)}})
    else $error("identification mode bits wrong");
  fifo_off_a: assert property (fcrWr && !wd[0] |=> rxCount_r == '0 && txCount_r == '0
                               && !fifoEn_r)
    else $error("fifos not emptied on disable");
  shadow_a: assert property (fcrWr |=> fifoCtlShadow == $past(wd))
    else $error("fifo control shadow stale");
  tmo_set_a: assert property (tmoHit ##1 (!rxPop && !rxFlush && fifoEn_r) |=> tmo_r)
    else $error("timeout flag not raised");
  thre_clr_a: assert property (rdIir && iid == `SPB_IID_THRE && !threSet
                               |=> !threPend_r)
    else $error("transmit empty not cleared");
  irq_gate_a: assert property (!interruptOutputGateBit |=> serIrqOe_n && !serIrq)
    else $error("interrupt driven with gate off");
  tx_load_a: assert property (txLoad |=> txBusy_r && txShift_r[8:1] == $past(txHead))
    else $error("shifter load wrong");

  tmo_c: cover property (tmoHit);
  thre_c: cover property (rdIir && iid == `SPB_IID_THRE);
  rx_full_c: cover property (fifoEn_r && rxFull);
  rx_trig_c: cover property (fifoEn_r && trig_r == 2'h3 && rdaEn);

endmodule // spb_uart

// ### test/spb_line_model.sv
// serial line partner: sends characters to the receiver, captures transmitted ones
`timescale 1ns/10ps

module spb_line_model
(
  // clock
  input  wire logic ref_clk,
  // serial lines
  output logic      rxSerial,
  input  wire logic txSerial
);
  logic [7:0] txLog [0:7];
  logic [7:0] capByte;
  logic       stopBad;
  int         txCount;

  // one 8N1 character, 16 clocks per bit since the tick runs every cycle
  task automatic send(input logic [7:0] b);
    int i;
    @(posedge ref_clk) rxSerial <= 1'b0;
    repeat (15) @(posedge ref_clk);
    for (i = 0; i < 8; i++)
    begin
      @(posedge ref_clk) rxSerial <= b[i];
      repeat (15) @(posedge ref_clk);
    end
    @(posedge ref_clk) rxSerial <= 1'b1;
    repeat (15) @(posedge ref_clk);
  endtask

  // capture on the falling edge, clear of the edge that launches the line
  initial
  begin
    int i;
    rxSerial = 1'b1;
    stopBad  = 1'b0;
    txCount  = 0;
    forever
    begin
      @(negedge ref_clk);
      if (txSerial === 1'b0)
      begin
        repeat (8) @(negedge ref_clk);
        for (i = 0; i < 8; i++)
        begin
          repeat (16) @(negedge ref_clk);
          capByte[i] = txSerial;
        end
        repeat (16) @(negedge ref_clk);
        if (txSerial !== 1'b1)
          stopBad = 1'b1;
        txLog[txCount[2:0]] = capByte;
        txCount++;
      end
    end
  end
endmodule // spb_line_model

// ### test/testbench.sv
// self-checking bench for the serial port buffer block
`timescale 1ns/10ps

module testbench
  import spb_pkg::*;
;
  logic       ref_clk;
  logic       reset;
  spb_req_s   req;
  logic [7:0] rdData;
  logic [7:0] shadow;
  logic       rxSerial;
  logic       txSerial;
  logic       divisor_latch_access_bit;
  logic       lsPend;
  logic       msPend;
  logic       gate;
  logic       irq;
  logic       irqOe_n;
  int         fails;
  int         comparisons;

  // ---------------------------------------------------------------
  // design and serial partner
  // ---------------------------------------------------------------
  spb_uart u_dut (
    .ref_clk(ref_clk), .reset(reset), .regReq(req), .regRdData(rdData),
    .rxSerial(rxSerial), .sampleTick(1'b1), .txSerial(txSerial),
    .divisorLatchAccessBit(divisor_latch_access_bit), .lineStatusPend(lsPend),
    .modemStatusPend(msPend), .interruptOutputGateBit(gate),
    .fifoCtlShadow(shadow), .serIrq(irq), .serIrqOe_n(irqOe_n)
  );
  spb_line_model u_line (.ref_clk(ref_clk), .rxSerial(rxSerial), .txSerial(txSerial));

  // 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // register port tasks and compares
  // ---------------------------------------------------------------
  task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk) req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic regRead(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk) req.rd <= 1'b0;
    #1 d = rdData;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    regRead(a, d);
    chk(n, e, d);
  endtask

  // bounded wait for the partner to finish n characters
  task automatic waitTx(input int n);
    int k;
    for (k = 0; k < 600 && u_line.txCount < n; k++)
      @(posedge ref_clk);
  endtask

  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog, about four times the expected run
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    results();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    int t;
    int k;
    int trg [4];
    trg = '{1, 4, 8, 14};
    fails = 0;
    comparisons = 0;
    req = '0;
    reset = 1'b1;
    divisor_latch_access_bit = 1'b0;
    lsPend = 1'b0;
    msPend = 1'b0;
    gate = 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    // masked sources report nothing even with transmit empty pending
    rchk("ien", 3'h1, 8'h00);
    rchk("iir", 3'h2, 8'h01);
    chk("irq", 8'h00, {7'h0, irq});
    regWrite(3'h1, 8'hFF);
    rchk("ien", 3'h1, 8'h0F);
    repeat (2) @(posedge ref_clk);
    chk("irq", 8'h01, {7'h0, irq});
    chk("irqOe", 8'h00, {7'h0, irqOe_n});
    rchk("iir", 3'h2, 8'h02);
    rchk("iir", 3'h2, 8'h01);
    @(posedge ref_clk) msPend <= 1'b1;
    rchk("iir", 3'h2, 8'h00);
    @(posedge ref_clk) lsPend <= 1'b1;
    rchk("iir", 3'h2, 8'h06);
    @(posedge ref_clk) gate <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irqOe", 8'h01, {7'h0, irqOe_n});
    chk("irq", 8'h00, {7'h0, irq});
    lsPend <= 1'b0;
    msPend <= 1'b0;
    gate <= 1'b1;
    // transmit: single byte, then two back to back through the fifo
    regWrite(3'h0, 8'hA5);
    waitTx(1);
    chk("tx0", 8'hA5, u_line.txLog[0]);
    regWrite(3'h2, 8'hC9);
    @(negedge ref_clk);
    chk("shadow", 8'hC9, shadow);
    regWrite(3'h0, 8'h3C);
    regWrite(3'h0, 8'hC3);
    waitTx(3);
    chk("tx1", 8'h3C, u_line.txLog[1]);
    chk("tx2", 8'hC3, u_line.txLog[2]);
    chk("stop", 8'h00, {7'h0, u_line.stopBad});
    // transmit flush drops queued bytes but lets the one in flight finish
    regWrite(3'h0, 8'h11);
    regWrite(3'h0, 8'h22);
    regWrite(3'h0, 8'h33);
    regWrite(3'h2, 8'hC5);
    waitTx(5);
    chk("txFlush", 8'h04, u_line.txCount[7:0]);
    chk("tx3", 8'h11, u_line.txLog[3]);
    // receive trigger levels, each after a receive flush
    regWrite(3'h1, 8'h01);
    for (t = 0; t < 4; t++)
    begin
      regWrite(3'h2, {t[1:0], 6'h03});
      for (k = 1; k < trg[t]; k++)
        u_line.send(8'h40 + k[7:0]);
      repeat (4) @(posedge ref_clk);
      rchk("iirBelow", 3'h2, 8'hC1);
      u_line.send(8'h5A);
      repeat (4) @(posedge ref_clk);
      rchk("iirTrig", 3'h2, 8'hC4);
    end
    // fourteen held; one pop drops below trigger
    rchk("rx0", 3'h0, 8'h41);
    rchk("iirPop", 3'h2, 8'hC1);
    // idle fifo raises the timeout only after four character times
    repeat (400) @(posedge ref_clk);
    rchk("iirEarly", 3'h2, 8'hC1);
    repeat (300) @(posedge ref_clk);
    rchk("iirTmo", 3'h2, 8'hCC);
    rchk("rx1", 3'h0, 8'h42);
    rchk("iirClr", 3'h2, 8'hC1);
    // leaving fifo mode discards the held bytes
    regWrite(3'h2, 8'h00);
    rchk("iirOff", 3'h2, 8'h01);
    chk("shadow", 8'h00, shadow);
    // one-byte holder outside fifo mode
    u_line.send(8'h96);
    repeat (4) @(posedge ref_clk);
    rchk("iirRda", 3'h2, 8'h04);
    rchk("rxHold", 3'h0, 8'h96);
    rchk("iirDone", 3'h2, 8'h01);
    // divisor latch access hides data and enable registers
    @(posedge ref_clk) divisor_latch_access_bit <= 1'b1;
    rchk("ienHid", 3'h1, 8'h00);
    regWrite(3'h0, 8'h77);
    waitTx(5);
    chk("txCount", 8'h04, u_line.txCount[7:0]);
    @(posedge ref_clk) divisor_latch_access_bit <= 1'b0;
    rchk("ien", 3'h1, 8'h01);
    rchk("unmapped", 3'h3, 8'h00);
    results();
  end
endmodule // testbench
